/* File: hw/drp_pkg.sv */
`default_nettype none
package drp_pkg;

	// ==========================================================
	// Operating and clocking modes.
	typedef enum logic [2:0] {
		DRP_OP_ROM = 3'h1,
		DRP_OP_DUAL = 3'h2,
		DRP_OP_TRUE_TWO_PORT = 3'h4
	} drp_op_mode_t;

	typedef enum logic [3:0] {
		DRP_CLK_SINGLE = 4'h1,
		DRP_CLK_IN_OUT = 4'h2,
		DRP_CLK_INDEP = 4'h4,
		DRP_CLK_RD_WR = 4'h8
	} drp_clk_mode_t;

	// ==========================================================
	// Reset values and defaults.
	localparam logic DRP_ADDR_RST_BIT = 1'b0;
	localparam logic DRP_RDEN_RST = 1'b0;
	localparam logic DRP_Q_RST_BIT = 1'b0;
	localparam logic DRP_RDEN_TIED = 1'b1;
	localparam int DRP_ADDR_W = 8;
	localparam int DRP_DATA_W = 8;
	localparam int DRP_ROM_MULT = 37;

	// ==========================================================
	// Selects the enable that governs one register group.
	function automatic logic drp_port_en(
		input drp_clk_mode_t m,
		input logic port_b,
		input logic out_side,
		input logic in_ce,
		input logic out_ce,
		input logic ce_b
	);
		case (m)
			DRP_CLK_SINGLE: drp_port_en = in_ce;
			DRP_CLK_IN_OUT: drp_port_en = out_side ? out_ce : in_ce;
			DRP_CLK_INDEP: drp_port_en = port_b ? ce_b : in_ce;
			DRP_CLK_RD_WR: drp_port_en = out_ce;
			default: drp_port_en = 1'b0;
		endcase
	endfunction : drp_port_en

endpackage : drp_pkg
`default_nettype wire

/* File: hw/drp_areg.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_areg #(
	parameter int AW = drp_pkg::DRP_ADDR_W,
	parameter bit CLR_EN = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic aclr_i,
	input wire logic en_i,
	input wire logic stall_i,
	input wire logic rden_i,
	input wire logic [AW-1:0] addr_i,
	output logic [AW-1:0] addr_o,
	output logic rden_o
);
	typedef struct packed {
		logic [AW-1:0] addr;
		logic rden;
	} drp_ast_t;

	localparam drp_ast_t RST_ST = '{addr: {AW{drp_pkg::DRP_ADDR_RST_BIT}},
		rden: drp_pkg::DRP_RDEN_RST};

	drp_ast_t st_r;
	drp_ast_t st_nxt;

	// ==========================================================
	// Address and read enable capture; stall holds only the address.
	always_comb begin
		st_nxt = st_r;
		if (en_i) begin
			if (!stall_i) begin
				st_nxt.addr = addr_i;
			end
			st_nxt.rden = rden_i;
		end
	end

	generate
		if (CLR_EN) begin : g_clr
			always_ff @(posedge sys_clk_i or posedge aclr_i) begin
				if (aclr_i) begin
					st_r <= RST_ST;
				end else if (!rst_n_i) begin
					st_r <= RST_ST;
				end else begin
					st_r <= st_nxt;
				end
			end
		end else begin : g_noclr
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					st_r <= RST_ST;
				end else begin
					st_r <= st_nxt;
				end
			end
		end
	endgenerate

	assign addr_o = st_r.addr;
	assign rden_o = st_r.rden;
endmodule : drp_areg
`default_nettype wire

/* File: hw/drp_qreg.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_qreg #(
	parameter int DW = drp_pkg::DRP_DATA_W,
	parameter bit CLR_EN = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic aclr_i,
	input wire logic en_i,
	input wire logic rden_i,
	input wire logic [DW-1:0] word_i,
	output logic [DW-1:0] q_o
);
	typedef struct packed {
		logic [DW-1:0] q;
	} drp_qst_t;

	localparam drp_qst_t RST_ST = '{q: {DW{drp_pkg::DRP_Q_RST_BIT}}};

	drp_qst_t st_r;
	drp_qst_t st_nxt;

	// ==========================================================
	// Output word register, loaded only on an enabled read.
	always_comb begin
		st_nxt = st_r;
		if (en_i && rden_i) begin
			st_nxt.q = word_i;
		end
	end

	generate
		if (CLR_EN) begin : g_clr
			always_ff @(posedge sys_clk_i or posedge aclr_i) begin
				if (aclr_i) begin
					st_r <= RST_ST;
				end else if (!rst_n_i) begin
					st_r <= RST_ST;
				end else begin
					st_r <= st_nxt;
				end
			end
		end else begin : g_noclr
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					st_r <= RST_ST;
				end else begin
					st_r <= st_nxt;
				end
			end
		end
	endgenerate

	assign q_o = st_r.q;
endmodule : drp_qreg
`default_nettype wire

/* File: hw/drp_rom_top.sv */
// Function
// - Port A address input is always present and driven in every mode.
// - Port B address and data output exist in dual and true two-port modes.
// - Each port has an optional read enable qualifying reads at its address.
// - While a port's stall is high its captured address is held.
// - Single clock mode: one clock and enable govern every register.
// - Input/output mode: input enable governs addresses, output enable the data.
// - Independent mode: port A clock governs all port A registers.
// - Read/write mode: read side governs read address, read enable and data.
// - Clock enables gate their registers; no update while deasserted.
// - Asynchronous clear resets registered ports without waiting for a clock edge.
// - Asynchronous clear effect is selectable for each registered port.
// - Each data output is as wide as that port's data word.
// - Port A data output is present in single, true two-port and ROM modes.
// - The dual-port version adds a second read address input.
// - Independent mode: port B has its own registers and clock enable.
`timescale 1ns/1ps
`default_nettype none
module drp_rom_top #(
	parameter int AW = drp_pkg::DRP_ADDR_W,
	parameter int DW = drp_pkg::DRP_DATA_W,
	parameter drp_pkg::drp_clk_mode_t CLK_MODE = drp_pkg::DRP_CLK_SINGLE,
	parameter drp_pkg::drp_op_mode_t OP_MODE = drp_pkg::DRP_OP_TRUE_TWO_PORT,
	parameter bit USE_RDEN_A = 1'b1,
	parameter bit USE_RDEN_B = 1'b1,
	parameter bit CLR_ADDR_A = 1'b1,
	parameter bit CLR_ADDR_B = 1'b1,
	parameter bit CLR_Q_A = 1'b1,
	parameter bit CLR_Q_B = 1'b1,
	parameter logic [DW-1:0] INIT_SEED = 8'h5a
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic aclr_i,
	input wire logic [AW-1:0] addr_a_i,
	input wire logic rden_a_i,
	input wire logic addr_stall_a_i,
	input wire logic [AW-1:0] addr_b_i,
	input wire logic rden_b_i,
	input wire logic addr_stall_b_i,
	input wire logic in_clk_en_i,
	input wire logic out_clk_en_i,
	input wire logic clk_en_b_i,
	output logic [DW-1:0] q_a_o,
	output logic [DW-1:0] q_b_o
);
	localparam int DEPTH = 1 << AW;
	localparam bit HAS_B = (OP_MODE != drp_pkg::DRP_OP_ROM);

	// ==========================================================
	// Stored contents, fixed at build time.
	function automatic logic [DW-1:0] rom_init(input int idx);
		int v;
		v = idx * drp_pkg::DRP_ROM_MULT + int'(INIT_SEED);
		rom_init = v[DW-1:0];
	endfunction : rom_init

	logic [DW-1:0] rom_mem [DEPTH];

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_rom
			assign rom_mem[gi] = rom_init(gi);
		end
	endgenerate

	// ==========================================================
	// Enable selection for each register group.
	logic a_in_en;
	logic a_out_en;
	logic b_in_en;
	logic b_out_en;
	logic rden_a_eff;
	logic rden_b_eff;

	assign a_in_en = drp_pkg::drp_port_en(CLK_MODE, 1'b0, 1'b0,
		in_clk_en_i, out_clk_en_i, clk_en_b_i);
	assign a_out_en = drp_pkg::drp_port_en(CLK_MODE, 1'b0, 1'b1,
		in_clk_en_i, out_clk_en_i, clk_en_b_i);
	assign b_in_en = HAS_B && drp_pkg::drp_port_en(CLK_MODE, 1'b1, 1'b0,
		in_clk_en_i, out_clk_en_i, clk_en_b_i);
	assign b_out_en = HAS_B && drp_pkg::drp_port_en(CLK_MODE, 1'b1, 1'b1,
		in_clk_en_i, out_clk_en_i, clk_en_b_i);
	assign rden_a_eff = USE_RDEN_A ? rden_a_i : drp_pkg::DRP_RDEN_TIED;
	assign rden_b_eff = USE_RDEN_B ? rden_b_i : drp_pkg::DRP_RDEN_TIED;

	// ==========================================================
	// Port A registers.
	logic [AW-1:0] a_addr;
	logic a_rden_r;
	logic [DW-1:0] a_word;
	logic [AW-1:0] b_addr;
	logic b_rden_r;
	logic [DW-1:0] b_word;

	drp_areg #(.AW(AW), .CLR_EN(CLR_ADDR_A)) u_areg_a (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.aclr_i(aclr_i),
		.en_i(a_in_en),
		.stall_i(addr_stall_a_i),
		.rden_i(rden_a_eff),
		.addr_i(addr_a_i),
		.addr_o(a_addr),
		.rden_o(a_rden_r)
	);

	assign a_word = rom_mem[a_addr];

	drp_qreg #(.DW(DW), .CLR_EN(CLR_Q_A)) u_qreg_a (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.aclr_i(aclr_i),
		.en_i(a_out_en),
		.rden_i(a_rden_r),
		.word_i(a_word),
		.q_o(q_a_o)
	);

	// ==========================================================
	// Port B registers, a second read address into the same contents.
	drp_areg #(.AW(AW), .CLR_EN(CLR_ADDR_B)) u_areg_b (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.aclr_i(aclr_i),
		.en_i(b_in_en),
		.stall_i(addr_stall_b_i),
		.rden_i(rden_b_eff),
		.addr_i(addr_b_i),
		.addr_o(b_addr),
		.rden_o(b_rden_r)
	);

	assign b_word = rom_mem[b_addr];

	drp_qreg #(.DW(DW), .CLR_EN(CLR_Q_B)) u_qreg_b (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.aclr_i(aclr_i),
		.en_i(b_out_en),
		.rden_i(b_rden_r),
		.word_i(b_word),
		.q_o(q_b_o)
	);

	// ==========================================================
	// Helper state that masks checks after any reset or clear.
	typedef struct packed {
		logic [1:0] quiet;
	} drp_hst_t;

	drp_hst_t hs_r;
	drp_hst_t hs_nxt;
	logic chk_off;

	always_comb begin
		hs_nxt = hs_r;
		hs_nxt.quiet = {hs_r.quiet[0], (!rst_n_i || aclr_i)};
	end

	always_ff @(posedge sys_clk_i) begin
		hs_r <= hs_nxt;
	end

	assign chk_off = !rst_n_i || aclr_i || (|hs_r.quiet);

	// ==========================================================
	// Checks.
	sequence s_a_capture;
		a_in_en && !addr_stall_a_i && rden_a_eff;
	endsequence

	sequence s_a_read;
		a_out_en;
	endsequence

	sequence s_b_capture;
		b_in_en && !addr_stall_b_i;
	endsequence

	sequence s_b_fetch;
		b_in_en && !addr_stall_b_i && rden_b_eff;
	endsequence

	sequence s_b_read;
		b_out_en;
	endsequence

	a_stall_holds_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		addr_stall_a_i |=> $stable(a_addr))
		else $error("port A address moved while stalled");

	a_stall_holds_b: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		addr_stall_b_i |=> $stable(b_addr))
		else $error("port B address moved while stalled");

	a_addr_capture_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		(a_in_en && !addr_stall_a_i) |=> (a_addr == $past(addr_a_i)))
		else $error("port A address not captured");

	a_addr_capture_b: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		s_b_capture |=> (b_addr == $past(addr_b_i)))
		else $error("port B address not captured");

	a_rden_gates_q: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		!a_rden_r |=> $stable(q_a_o))
		else $error("port A output changed without read enable");

	a_read_data_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		(a_out_en && a_rden_r) |=> (q_a_o == $past(a_word)))
		else $error("port A output does not match stored word");

	a_read_data_b: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		(b_out_en && b_rden_r) |=> (q_b_o == $past(b_word)))
		else $error("port B output does not match stored word");

	a_two_step_read: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		s_a_capture ##1 s_a_read |=> (q_a_o == rom_mem[$past(addr_a_i, 2)]))
		else $error("port A capture then read gave the wrong word");

	a_en_gate_all: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		(!a_in_en && !a_out_en) |=> ($stable(a_addr) && $stable(q_a_o)))
		else $error("port A register updated while disabled");

	a_addr_hold_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		!a_in_en |=> $stable(a_addr))
		else $error("port A address moved with its input enable low");

	a_rden_take_a: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		a_in_en |=> (a_rden_r == $past(rden_a_eff)))
		else $error("port A read enable not captured");

	// ==========================================================
	// Checks that watch the port B registers, then the per-mode checks, and the clear and width checks on both ports.
	a_rden_take_b: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		b_in_en |=> (b_rden_r == $past(rden_b_eff)))
		else $error("port B read enable not captured");

	a_rden_gates_qb: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		!b_rden_r |=> $stable(q_b_o))
		else $error("port B output changed without read enable");

	a_two_step_b: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		s_b_fetch ##1 s_b_read |=> (q_b_o == rom_mem[$past(addr_b_i, 2)]))
		else $error("port B capture then read gave the wrong word");

	a_en_gate_b: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		(!b_in_en && !b_out_en) |=> ($stable(b_addr) && $stable(q_b_o)))
		else $error("port B register updated while disabled");

	generate
		if (CLK_MODE == drp_pkg::DRP_CLK_SINGLE) begin : g_chk_single
			a_single_clk_en: assert property (@(posedge sys_clk_i) disable iff (chk_off)
				!in_clk_en_i |=> ($stable(a_addr) && $stable(q_a_o) && $stable(b_addr)))
				else $error("register moved with the single enable low");
		end
		if (CLK_MODE == drp_pkg::DRP_CLK_IN_OUT) begin : g_chk_inout
			a_out_clk_q: assert property (@(posedge sys_clk_i) disable iff (chk_off)
				(!out_clk_en_i && in_clk_en_i && !addr_stall_a_i)
				|=> ($stable(q_a_o) && (a_addr == $past(addr_a_i))))
				else $error("input and output enables not split");
		end
		if (CLK_MODE == drp_pkg::DRP_CLK_INDEP) begin : g_chk_indep
			a_port_a_clk: assert property (@(posedge sys_clk_i) disable iff (chk_off)
				!in_clk_en_i |=> ($stable(a_addr) && $stable(q_a_o)))
				else $error("port A moved with its enable low");
			a_port_b_clk: assert property (@(posedge sys_clk_i) disable iff (chk_off)
				!clk_en_b_i |=> ($stable(b_addr) && $stable(q_b_o)))
				else $error("port B moved with its enable low");
		end
		if (CLK_MODE == drp_pkg::DRP_CLK_RD_WR) begin : g_chk_rdwr
			a_read_clk_all: assert property (@(posedge sys_clk_i) disable iff (chk_off)
				!out_clk_en_i |=> ($stable(a_addr) && $stable(a_rden_r) && $stable(q_a_o)))
				else $error("read side moved with read enable low");
		end
		if (!HAS_B) begin : g_chk_nob
			a_port_b_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
				##1 (q_b_o == '0))
				else $error("port B output active in single-address mode");
		end
		if (CLR_Q_A) begin : g_chk_clr
			a_clear_q_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
				aclr_i |-> ((q_a_o == '0) && (!CLR_ADDR_A || (a_addr == '0 && !a_rden_r))))
				else $error("clear did not reset port A");
		end
		if (HAS_B && CLR_Q_B) begin : g_chk_clr_b
			a_clear_q_b: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
				aclr_i |-> ((q_b_o == '0) && (!CLR_ADDR_B || (b_addr == '0 && !b_rden_r))))
				else $error("clear did not reset port B");
		end
		if (HAS_B && !CLR_Q_B) begin : g_chk_keep_b
			a_clear_keep_b: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
				!b_out_en |=> $stable(q_b_o))
				else $error("port B output moved although its clear is off");
		end
	endgenerate

	a_width_match: assert property (@(posedge sys_clk_i) disable iff (chk_off)
		($bits(q_a_o) == DW) && ($bits(q_b_o) == DW))
		else $error("output width differs from data word");

endmodule : drp_rom_top
`default_nettype wire

/* File: test/drp_user_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Fabric user logic: turns one random word into read-port requests.
module drp_user_model (
	input wire logic go_i,
	input wire logic [31:0] rnd_i,
	output logic [drp_pkg::DRP_ADDR_W-1:0] addr_a_o,
	output logic [drp_pkg::DRP_ADDR_W-1:0] addr_b_o,
	output logic rden_a_o,
	output logic rden_b_o,
	output logic stall_a_o,
	output logic stall_b_o,
	output logic in_en_o,
	output logic out_en_o,
	output logic en_b_o
);
	assign addr_a_o = rnd_i[7:0];
	assign addr_b_o = rnd_i[15:8];
	assign rden_a_o = go_i & (rnd_i[16] | rnd_i[17]);
	assign rden_b_o = go_i & (rnd_i[18] | rnd_i[19]);
	assign stall_a_o = rnd_i[20] & rnd_i[21];
	assign stall_b_o = rnd_i[22] & rnd_i[23];
	assign in_en_o = go_i & (rnd_i[24] | rnd_i[25]);
	assign out_en_o = go_i & (rnd_i[26] | rnd_i[27]);
	assign en_b_o = go_i & rnd_i[28];
endmodule : drp_user_model
`default_nettype wire

/* File: test/drp_rom_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the two-port read-only memory in three enable and port modes.
module drp_rom_top_bench;
	logic sys_clk, rst_n, aclr, go;
	logic [31:0] rnd;
	logic [7:0] addr_a, addr_b, q_a, q_b, q_a2, q_b2, q_a3, q_b3;
	logic rden_a, rden_b, stall_a, stall_b, in_en, out_en, en_b;
	int n_errors, n_checks, cyc, ma, mb, ra, rb, qa, qb;
	int ma2, mb2, ra2, rb2, qa2, qb2, ma3, ra3, qa3;

	drp_user_model USER (.go_i(go), .rnd_i(rnd), .addr_a_o(addr_a), .addr_b_o(addr_b),
		.rden_a_o(rden_a), .rden_b_o(rden_b), .stall_a_o(stall_a), .stall_b_o(stall_b),
		.in_en_o(in_en), .out_en_o(out_en), .en_b_o(en_b));

	drp_rom_top #(.CLK_MODE(drp_pkg::DRP_CLK_IN_OUT)) DUT (.sys_clk_i(sys_clk),
		.rst_n_i(rst_n), .aclr_i(aclr), .addr_a_i(addr_a), .rden_a_i(rden_a),
		.addr_stall_a_i(stall_a), .addr_b_i(addr_b), .rden_b_i(rden_b),
		.addr_stall_b_i(stall_b), .in_clk_en_i(in_en), .out_clk_en_i(out_en),
		.clk_en_b_i(en_b), .q_a_o(q_a), .q_b_o(q_b));

	drp_rom_top #(.CLK_MODE(drp_pkg::DRP_CLK_INDEP), .USE_RDEN_B(1'b0), .CLR_ADDR_B(1'b0),
		.CLR_Q_B(1'b0)) DUT_IND (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .aclr_i(aclr),
		.addr_a_i(addr_a), .rden_a_i(rden_a), .addr_stall_a_i(stall_a), .addr_b_i(addr_b),
		.rden_b_i(rden_b), .addr_stall_b_i(stall_b), .in_clk_en_i(in_en),
		.out_clk_en_i(out_en), .clk_en_b_i(en_b), .q_a_o(q_a2), .q_b_o(q_b2));

	drp_rom_top #(.CLK_MODE(drp_pkg::DRP_CLK_RD_WR), .OP_MODE(drp_pkg::DRP_OP_ROM),
		.USE_RDEN_A(1'b0)) DUT_RW (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .aclr_i(aclr),
		.addr_a_i(addr_a), .rden_a_i(rden_a), .addr_stall_a_i(stall_a), .addr_b_i(addr_b),
		.rden_b_i(rden_b), .addr_stall_b_i(stall_b), .in_clk_en_i(in_en),
		.out_clk_en_i(out_en), .clk_en_b_i(en_b), .q_a_o(q_a3), .q_b_o(q_b3));

	// ==========================================================
	// Clock, stored words and checking.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	function automatic int rom(input int i);
		return (i * drp_pkg::DRP_ROM_MULT + 32'h5a) & 32'hff;
	endfunction : rom

	task automatic chk_q(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_q

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	// ==========================================================
	// Behavioural models: split input/output enables, independent port enables, and read side only.
	always @(posedge sys_clk) begin
		if (!rst_n || aclr) begin
			ma = 0;
			mb = 0;
			ra = 0;
			rb = 0;
			qa = 0;
			qb = 0;
		end else begin
			if (out_en && ra != 0) qa = rom(ma);
			if (out_en && rb != 0) qb = rom(mb);
			if (in_en) begin
				if (!stall_a) ma = addr_a;
				if (!stall_b) mb = addr_b;
				ra = rden_a;
				rb = rden_b;
			end
		end
		if (!rst_n) begin
			ma2 = 0;
			mb2 = 0;
			ra2 = 0;
			rb2 = 0;
			qa2 = 0;
			qb2 = 0;
		end else begin
			if (aclr) begin
				ma2 = 0;
				ra2 = 0;
				qa2 = 0;
			end else if (in_en) begin
				if (ra2 != 0) qa2 = rom(ma2);
				if (!stall_a) ma2 = addr_a;
				ra2 = rden_a;
			end
			if (en_b) begin
				if (rb2 != 0) qb2 = rom(mb2);
				if (!stall_b) mb2 = addr_b;
				rb2 = 1;
			end
		end
		if (!rst_n || aclr) begin
			ma3 = 0;
			ra3 = 0;
			qa3 = 0;
		end else if (out_en) begin
			if (ra3 != 0) qa3 = rom(ma3);
			if (!stall_a) ma3 = addr_a;
			ra3 = 1;
		end
		#1;
		chk_q("q_a", qa[7:0], q_a);
		chk_q("q_b", qb[7:0], q_b);
		chk_q("q_a indep", qa2[7:0], q_a2);
		chk_q("q_b indep", qb2[7:0], q_b2);
		chk_q("q_a rdwr", qa3[7:0], q_a3);
		chk_q("q_b rom", 8'h00, q_b3);
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			$display("[FAIL] timeout expected finish seen hang");
			end_sim();
		end
	end

	// ==========================================================
	// Stimulus.
	task automatic traffic(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#2;
			rnd = $urandom;
		end
	endtask : traffic

	task automatic do_reset();
		@(posedge sys_clk);
		#2;
		rst_n = 1'b0;
		go = 1'b0;
		repeat (2) @(posedge sys_clk);
		#2;
		rst_n = 1'b1;
		go = 1'b1;
	endtask : do_reset

	initial begin
		rst_n = 1'b0;
		aclr = 1'b0;
		go = 1'b0;
		rnd = 32'h0000_0000;
		n_errors = 0;
		n_checks = 0;
		cyc = 0;
		void'($urandom(11101));
		repeat (2) @(posedge sys_clk);
		#2;
		rst_n = 1'b1;
		go = 1'b1;
		$display("Reset test done");
		traffic(800);
		$display("Random read test done");
		@(posedge sys_clk);
		#2;
		go = 1'b0;
		aclr = 1'b1;
		qa = 0;
		qb = 0;
		#3;
		chk_q("q_a clear", 8'h00, q_a);
		chk_q("q_b clear", 8'h00, q_b);
		chk_q("q_a indep clear", 8'h00, q_a2);
		chk_q("q_b indep hold", qb2[7:0], q_b2);
		chk_q("q_a rdwr clear", 8'h00, q_a3);
		@(posedge sys_clk);
		#2;
		aclr = 1'b0;
		@(posedge sys_clk);
		#2;
		go = 1'b1;
		traffic(200);
		$display("Clear test done");
		do_reset();
		traffic(200);
		$display("Second reset test done");
		end_sim();
	end
endmodule : drp_rom_top_bench
`default_nettype wire
